// ===== bench/scc_core_model.sv
// Core model issuing coprocessor transfers and abort events
`timescale 1ns/1ps
module scc_core_model (
  input wire logic clk_i,
  input wire logic [31:0] xfer_rdata_i,
  input wire logic xfer_rvalid_i,
  input wire logic undef_trap_i,
  output logic xfer_valid_o,
  output logic xfer_write_o,
  output logic xfer_priv_o,
  output logic xfer_other_o,
  output logic [3:0] xfer_crn_o,
  output logic [2:0] xfer_op2_o,
  output logic [31:0] xfer_wdata_o,
  output logic data_abort_o,
  output logic [3:0] abort_domain_o,
  output logic [3:0] abort_type_o,
  output logic [31:0] vaddr_o,
  output logic prefetch_abort_o,
  output logic [3:0] pf_domain_o,
  output logic [3:0] pf_type_o
);
  initial begin
    {xfer_valid_o, xfer_write_o, xfer_priv_o, xfer_other_o, xfer_crn_o, xfer_op2_o} = '0;
    xfer_wdata_o = 32'h0;
    {data_abort_o, abort_domain_o, abort_type_o, vaddr_o} = '0;
    {prefetch_abort_o, pf_domain_o, pf_type_o} = '0;
  end

  // One transfer; callers avoid register 4 and write reserved fields as required
  task automatic xfer(input logic w, input logic p, input logic o, input logic [3:0] crn,
      input logic [2:0] op2, input logic [31:0] wd, output logic [31:0] rd, output logic rv, output logic tr);
    @(posedge clk_i);
    #1;
    xfer_valid_o = 1'b1;
    xfer_write_o = w;
    xfer_priv_o = p;
    xfer_other_o = o;
    xfer_crn_o = crn;
    xfer_op2_o = op2;
    xfer_wdata_o = wd;
    @(posedge clk_i);
    #1;
    rd = xfer_rdata_i;
    rv = xfer_rvalid_i;
    tr = undef_trap_i;
    xfer_valid_o = 1'b0;
    xfer_wdata_o = ~wd;
  endtask

  // One-cycle abort pulse with its fields
  task automatic abort(input logic pf, input logic [3:0] dom, input logic [3:0] typ, input logic [31:0] addr);
    @(posedge clk_i);
    #1;
    data_abort_o = ~pf;
    prefetch_abort_o = pf;
    {abort_domain_o, pf_domain_o, abort_type_o, pf_type_o} = {dom, dom, typ, typ};
    vaddr_o = addr;
    @(posedge clk_i);
    #1;
    {data_abort_o, prefetch_abort_o} = 2'h0;
    {abort_domain_o, pf_domain_o, abort_type_o, pf_type_o} = ~{dom, dom, typ, typ};
    vaddr_o = ~addr;
  endtask
endmodule

// ===== bench/tb_scc_regs.sv
// Testbench for the system control register bank
`timescale 1ns/1ps
module tb_scc_regs;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic vector_init_pin_i = 1'b1;
  logic xfer_valid_i, xfer_write_i, xfer_priv_i, xfer_other_i, data_abort_i, prefetch_abort_i;
  logic [3:0] xfer_crn_i, abort_domain_i, abort_type_i, pf_domain_i, pf_type_i;
  logic [2:0] xfer_op2_i;
  logic [31:0] xfer_wdata_i, modified_virtual_address_i, xfer_rdata_o, vector_base_o, domain_access_o, rdv;
  logic xfer_rvalid_o, undef_trap_o, async_clock_select_o, not_fast_bus_select_o, round_robin_replace_o;
  logic high_vectors_o, icache_enable_o, rom_protect_o, system_protect_o, big_endian_o;
  logic dcache_enable_o, align_check_o, mmu_enable_o, rvv, trv;
  logic [17:0] table_base_pointer_o;
  logic [10:0] ctl;
  int mismatches = 0;
  int n_compared = 0;

  assign ctl = {async_clock_select_o, not_fast_bus_select_o, round_robin_replace_o, high_vectors_o,
    icache_enable_o, rom_protect_o, system_protect_o, big_endian_o, dcache_enable_o, align_check_o, mmu_enable_o};

  always #10 clk_i = ~clk_i;

  scc_regs u_dut (.clk_i, .arst_n_i, .ce_i, .vector_init_pin_i, .xfer_valid_i, .xfer_write_i, .xfer_priv_i,
    .xfer_other_i, .xfer_crn_i, .xfer_op2_i, .xfer_wdata_i, .data_abort_i, .abort_domain_i, .abort_type_i,
    .modified_virtual_address_i, .prefetch_abort_i, .pf_domain_i, .pf_type_i, .xfer_rdata_o, .xfer_rvalid_o,
    .undef_trap_o, .async_clock_select_o, .not_fast_bus_select_o, .round_robin_replace_o, .high_vectors_o,
    .vector_base_o, .icache_enable_o, .rom_protect_o, .system_protect_o, .big_endian_o, .dcache_enable_o,
    .align_check_o, .mmu_enable_o, .table_base_pointer_o, .domain_access_o);

  scc_core_model u_core (.clk_i, .xfer_rdata_i(xfer_rdata_o), .xfer_rvalid_i(xfer_rvalid_o),
    .undef_trap_i(undef_trap_o), .xfer_valid_o(xfer_valid_i), .xfer_write_o(xfer_write_i),
    .xfer_priv_o(xfer_priv_i), .xfer_other_o(xfer_other_i), .xfer_crn_o(xfer_crn_i), .xfer_op2_o(xfer_op2_i),
    .xfer_wdata_o(xfer_wdata_i), .data_abort_o(data_abort_i), .abort_domain_o(abort_domain_i),
    .abort_type_o(abort_type_i), .vaddr_o(modified_virtual_address_i), .prefetch_abort_o(prefetch_abort_i),
    .pf_domain_o(pf_domain_i), .pf_type_o(pf_type_i));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] crn, input logic [2:0] op2, input logic [31:0] wd);
    u_core.xfer(1'b1, 1'b1, 1'b0, crn, op2, wd, rdv, rvv, trv);
  endtask

  task automatic rd(input string nm, input logic [3:0] crn, input logic [2:0] op2, input logic [31:0] exp);
    u_core.xfer(1'b0, 1'b1, 1'b0, crn, op2, 32'h0, rdv, rvv, trv);
    chk({nm, "_rvalid"}, 32'h1, {31'h0, rvv});
    chk({nm, "_trap"}, 32'h0, {31'h0, trv});
    chk(nm, exp, rdv);
  endtask

  task automatic t_reset(input logic pin);
    @(posedge clk_i);
    #1;
    arst_n_i = 1'b0;
    vector_init_pin_i = pin;
    repeat (16) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    @(posedge clk_i);
    #1;
    chk("vector_base", pin ? 32'hffff_0000 : 32'h0, vector_base_o);
    chk("ctl_reset", {21'h0, 3'h0, pin, 7'h0}, {21'h0, ctl});
    rd("ctrl_reset", 4'h1, 3'h0, {18'h0, pin, 13'h0078});
  endtask

  task automatic t_ctrl();
    int bits[12] = '{31, 30, 14, 13, 12, 9, 8, 7, 2, 1, 0, 31};
    logic [31:0] v;
    for (int i = 0; i < 12; i++) begin
      v = (32'h1 << bits[i]) | ((i == 11) ? 32'h4000_0078 : 32'h78);
      wr(4'h1, 3'h0, v);
      chk("ctl_out", (i == 11) ? 32'h600 : (32'h400 >> i), {21'h0, ctl});
      chk("vector_base", (i == 3) ? 32'hffff_0000 : 32'h0, vector_base_o);
      rd("ctrl", 4'h1, 3'h0, v);
    end
  endtask

  task automatic t_tables();
    wr(4'h2, 3'h0, 32'habcd_c000);
    chk("table_ptr", 32'h0002_af37, {14'h0, table_base_pointer_o});
    rd("table_base", 4'h2, 3'h0, 32'habcd_c000);
    wr(4'h3, 3'h0, 32'h9b2d_e4f6);
    chk("domain_out", 32'h9b2d_e4f6, domain_access_o);
    rd("dac", 4'h3, 3'h0, 32'h9b2d_e4f6);
  endtask

  task automatic t_fault();
    wr(4'h5, 3'h0, 32'ha5);
    wr(4'h5, 3'h1, 32'h3c);
    rd("dfsr", 4'h5, 3'h0, 32'ha5);
    rd("pfsr", 4'h5, 3'h1, 32'h3c);
    u_core.abort(1'b0, 4'h3, 4'h9, 32'h8765_4321);
    rd("dfsr_abort", 4'h5, 3'h0, 32'h39);
    rd("far_abort", 4'h6, 3'h0, 32'h8765_4321);
    rd("pfsr_kept", 4'h5, 3'h1, 32'h3c);
    u_core.abort(1'b1, 4'hc, 4'h5, 32'h1111_2222);
    rd("pfsr_abort", 4'h5, 3'h1, 32'hc5);
    rd("far_kept", 4'h6, 3'h0, 32'h8765_4321);
    rd("dfsr_kept", 4'h5, 3'h0, 32'h39);
    wr(4'h6, 3'h0, 32'h0bad_f00d);
    rd("far_write", 4'h6, 3'h0, 32'h0bad_f00d);
  endtask

  task automatic t_trap();
    u_core.xfer(1'b1, 1'b0, 1'b0, 4'h3, 3'h0, 32'hffff_ffff, rdv, rvv, trv);
    chk("trap_user", 32'h1, {31'h0, trv});
    u_core.xfer(1'b0, 1'b1, 1'b1, 4'h3, 3'h0, 32'h0, rdv, rvv, trv);
    chk("trap_other", 32'h2, {30'h0, trv, rvv});
    rd("dac_kept", 4'h3, 3'h0, 32'h9b2d_e4f6);
    rd("unmapped", 4'h7, 3'h0, 32'h0);
    rd("ctrl_op2", 4'h1, 3'h2, 32'h0);
  endtask

  task automatic t_freeze();
    @(posedge clk_i);
    #1;
    ce_i = 1'b0;
    wr(4'h3, 3'h0, 32'h0);
    chk("domain_frozen", 32'h9b2d_e4f6, domain_access_o);
    ce_i = 1'b1;
    rd("dac_frozen", 4'h3, 3'h0, 32'h9b2d_e4f6);
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    t_reset(1'b1);
    t_reset(1'b0);
    t_ctrl();
    t_tables();
    t_fault();
    t_trap();
    t_freeze();
    end_sim();
  end

  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule

// ===== hdl/scc_cfg.svh
// Constants for the system control register bank
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH
`define SCC_CRN_CTRL 4'h1
`define SCC_CRN_TABLE 4'h2
`define SCC_CRN_DAC 4'h3
`define SCC_CRN_STATUS 4'h5
`define SCC_CRN_FAR 4'h6
`define SCC_OP2_DATA 3'h0
`define SCC_OP2_PREF 3'h1
`define SCC_CR_ASYNC 31
`define SCC_CR_NOT_FAST 30
`define SCC_CR_ROUND_ROBIN 14
`define SCC_CR_V 13
`define SCC_CR_I 12
`define SCC_CR_R 9
`define SCC_CR_S 8
`define SCC_CR_B 7
`define SCC_CR_C 2
`define SCC_CR_A 1
`define SCC_CR_M 0
`define SCC_CR_RSV_HI 2'h0
`define SCC_CR_RSV_LO 4'hf
`define SCC_CTRL_RST 1'h0
`define SCC_TABLE_LSB 14
`define SCC_VEC_LOW 16'h0000
`define SCC_VEC_HIGH 16'hffff
`define SCC_WORD_RST 32'h0000_0000
`define SCC_STATUS_RST 8'h00
`endif

// ===== hdl/scc_pkg.sv
// Types for the system control register bank
package scc_pkg;
  typedef enum logic [2:0] {
    SCC_SEL_NONE = 3'h0,
    SCC_SEL_CTRL = 3'h1,
    SCC_SEL_TABLE = 3'h3,
    SCC_SEL_DAC = 3'h2,
    SCC_SEL_DFSR = 3'h6,
    SCC_SEL_PFSR = 3'h7,
    SCC_SEL_FAR = 3'h5
  } scc_sel_type;

  typedef struct packed {
    logic init_done;
    logic async_clk;
    logic not_fast;
    logic round_robin;
    logic v;
    logic ic;
    logic rp;
    logic sp;
    logic be;
    logic dc;
    logic al;
    logic mm;
    logic [15:0] vec_hi;
    logic [17:0] table_base;
    logic [31:0] dac;
    logic [7:0] dfsr;
    logic [7:0] pfsr;
    logic [31:0] fault_address;
    logic [31:0] rdata;
    logic rvalid;
    logic undef;
  } scc_state_type;
endpackage

// ===== hdl/scc_regs.sv
// System control register bank for coprocessor transfers
`timescale 1ns/1ps
`include "scc_cfg.svh"
module scc_regs (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic vector_init_pin_i,
  input wire logic xfer_valid_i,
  input wire logic xfer_write_i,
  input wire logic xfer_priv_i,
  input wire logic xfer_other_i,
  input wire logic [3:0] xfer_crn_i,
  input wire logic [2:0] xfer_op2_i,
  input wire logic [31:0] xfer_wdata_i,
  input wire logic data_abort_i,
  input wire logic [3:0] abort_domain_i,
  input wire logic [3:0] abort_type_i,
  input wire logic [31:0] modified_virtual_address_i,
  input wire logic prefetch_abort_i,
  input wire logic [3:0] pf_domain_i,
  input wire logic [3:0] pf_type_i,
  output logic [31:0] xfer_rdata_o,
  output logic xfer_rvalid_o,
  output logic undef_trap_o,
  output logic async_clock_select_o,
  output logic not_fast_bus_select_o,
  output logic round_robin_replace_o,
  output logic high_vectors_o,
  output logic [31:0] vector_base_o,
  output logic icache_enable_o,
  output logic rom_protect_o,
  output logic system_protect_o,
  output logic big_endian_o,
  output logic dcache_enable_o,
  output logic align_check_o,
  output logic mmu_enable_o,
  output logic [17:0] table_base_pointer_o,
  output logic [31:0] domain_access_o
);

  // ********************************
  // Register select decode
  // ********************************
  function automatic scc_pkg::scc_sel_type sel_of(input logic [3:0] crn, input logic [2:0] op2);
    scc_pkg::scc_sel_type s;
    s = scc_pkg::SCC_SEL_NONE;
    case (crn)
      `SCC_CRN_CTRL: begin
        if (op2 == `SCC_OP2_DATA) s = scc_pkg::SCC_SEL_CTRL;
      end
      `SCC_CRN_TABLE: begin
        if (op2 == `SCC_OP2_DATA) s = scc_pkg::SCC_SEL_TABLE;
      end
      `SCC_CRN_DAC: begin
        if (op2 == `SCC_OP2_DATA) s = scc_pkg::SCC_SEL_DAC;
      end
      `SCC_CRN_STATUS: begin
        if (op2 == `SCC_OP2_DATA) s = scc_pkg::SCC_SEL_DFSR;
        else if (op2 == `SCC_OP2_PREF) s = scc_pkg::SCC_SEL_PFSR;
      end
      `SCC_CRN_FAR: begin
        if (op2 == `SCC_OP2_DATA) s = scc_pkg::SCC_SEL_FAR;
      end
      default: begin
        s = scc_pkg::SCC_SEL_NONE;
      end
    endcase
    return s;
  endfunction

  // ********************************
  // State
  // ********************************
  scc_pkg::scc_state_type st_r;
  scc_pkg::scc_state_type st_nxt;
  scc_pkg::scc_sel_type sel;
  logic acc_ok;
  logic wr;

  always_comb begin
    sel = sel_of(xfer_crn_i, xfer_op2_i);
    acc_ok = xfer_valid_i && xfer_priv_i && !xfer_other_i;
    wr = acc_ok && xfer_write_i;
  end

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.undef = xfer_valid_i && !(xfer_priv_i && !xfer_other_i);
    if (!st_r.init_done) begin
      st_nxt.init_done = 1'b1;
      st_nxt.v = vector_init_pin_i;
    end
    if (acc_ok && !xfer_write_i) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = `SCC_WORD_RST;
      case (sel)
        scc_pkg::SCC_SEL_CTRL: begin
          st_nxt.rdata[`SCC_CR_ASYNC] = st_r.async_clk;
          st_nxt.rdata[`SCC_CR_NOT_FAST] = st_r.not_fast;
          st_nxt.rdata[`SCC_CR_ROUND_ROBIN] = st_r.round_robin;
          st_nxt.rdata[`SCC_CR_V] = st_r.v;
          st_nxt.rdata[`SCC_CR_I] = st_r.ic;
          st_nxt.rdata[11:10] = `SCC_CR_RSV_HI;
          st_nxt.rdata[`SCC_CR_R] = st_r.rp;
          st_nxt.rdata[`SCC_CR_S] = st_r.sp;
          st_nxt.rdata[`SCC_CR_B] = st_r.be;
          st_nxt.rdata[6:3] = `SCC_CR_RSV_LO;
          st_nxt.rdata[`SCC_CR_C] = st_r.dc;
          st_nxt.rdata[`SCC_CR_A] = st_r.al;
          st_nxt.rdata[`SCC_CR_M] = st_r.mm;
        end
        scc_pkg::SCC_SEL_TABLE: begin
          st_nxt.rdata[31:`SCC_TABLE_LSB] = st_r.table_base;
        end
        scc_pkg::SCC_SEL_DAC: begin
          st_nxt.rdata = st_r.dac;
        end
        scc_pkg::SCC_SEL_DFSR: begin
          st_nxt.rdata[7:0] = st_r.dfsr;
        end
        scc_pkg::SCC_SEL_PFSR: begin
          st_nxt.rdata[7:0] = st_r.pfsr;
        end
        scc_pkg::SCC_SEL_FAR: begin
          st_nxt.rdata = st_r.fault_address;
        end
        default: begin
          st_nxt.rdata = `SCC_WORD_RST;
        end
      endcase
    end
    if (wr) begin
      case (sel)
        scc_pkg::SCC_SEL_CTRL: begin
          st_nxt.async_clk = xfer_wdata_i[`SCC_CR_ASYNC];
          st_nxt.not_fast = xfer_wdata_i[`SCC_CR_NOT_FAST];
          st_nxt.round_robin = xfer_wdata_i[`SCC_CR_ROUND_ROBIN];
          st_nxt.v = xfer_wdata_i[`SCC_CR_V];
          st_nxt.ic = xfer_wdata_i[`SCC_CR_I];
          st_nxt.rp = xfer_wdata_i[`SCC_CR_R];
          st_nxt.sp = xfer_wdata_i[`SCC_CR_S];
          st_nxt.be = xfer_wdata_i[`SCC_CR_B];
          st_nxt.dc = xfer_wdata_i[`SCC_CR_C];
          st_nxt.al = xfer_wdata_i[`SCC_CR_A];
          st_nxt.mm = xfer_wdata_i[`SCC_CR_M];
          st_nxt.init_done = 1'b1;
        end
        scc_pkg::SCC_SEL_TABLE: begin
          st_nxt.table_base = xfer_wdata_i[31:`SCC_TABLE_LSB];
        end
        scc_pkg::SCC_SEL_DAC: begin
          st_nxt.dac = xfer_wdata_i;
        end
        scc_pkg::SCC_SEL_DFSR: begin
          st_nxt.dfsr = xfer_wdata_i[7:0];
        end
        scc_pkg::SCC_SEL_PFSR: begin
          st_nxt.pfsr = xfer_wdata_i[7:0];
        end
        scc_pkg::SCC_SEL_FAR: begin
          st_nxt.fault_address = xfer_wdata_i;
        end
        default: begin
          st_nxt.fault_address = st_nxt.fault_address;
        end
      endcase
    end
    // Hardware fault capture wins over a same-cycle write
    if (data_abort_i) begin
      st_nxt.dfsr = {abort_domain_i, abort_type_i};
      st_nxt.fault_address = modified_virtual_address_i;
    end
    if (prefetch_abort_i) begin
      st_nxt.pfsr = {pf_domain_i, pf_type_i};
    end
    st_nxt.vec_hi = st_nxt.v ? `SCC_VEC_HIGH : `SCC_VEC_LOW;
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign xfer_rdata_o = st_r.rdata;
  assign xfer_rvalid_o = st_r.rvalid;
  assign undef_trap_o = st_r.undef;
  assign async_clock_select_o = st_r.async_clk;
  assign not_fast_bus_select_o = st_r.not_fast;
  assign round_robin_replace_o = st_r.round_robin;
  assign high_vectors_o = st_r.v;
  assign vector_base_o = {st_r.vec_hi, `SCC_VEC_LOW};
  assign icache_enable_o = st_r.ic;
  assign rom_protect_o = st_r.rp;
  assign system_protect_o = st_r.sp;
  assign big_endian_o = st_r.be;
  assign dcache_enable_o = st_r.dc;
  assign align_check_o = st_r.al;
  assign mmu_enable_o = st_r.mm;
  assign table_base_pointer_o = st_r.table_base;
  assign domain_access_o = st_r.dac;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_dac_write;
    ce_i && xfer_valid_i && xfer_write_i && xfer_priv_i && !xfer_other_i
      && xfer_crn_i == `SCC_CRN_DAC && xfer_op2_i == `SCC_OP2_DATA;
  endsequence

  sequence s_dac_read;
    ce_i && xfer_valid_i && !xfer_write_i && xfer_priv_i && !xfer_other_i
      && xfer_crn_i == `SCC_CRN_DAC && xfer_op2_i == `SCC_OP2_DATA;
  endsequence

  a_undef_trap: assert property (ce_i && xfer_valid_i && !xfer_priv_i |=> undef_trap_o && !xfer_rvalid_o)
    else $error("Unprivileged transfer not trapped");

  a_unpriv_ctrl: assert property (ce_i && xfer_valid_i && xfer_write_i && !xfer_priv_i |=> $stable(mmu_enable_o) && $stable(big_endian_o))
    else $error("Unprivileged write changed control");

  a_vector_init: assert property (ce_i && !st_r.init_done && !wr |=> high_vectors_o == $past(vector_init_pin_i))
    else $error("Vector bit did not follow init pin");

  a_vector_base: assert property (vector_base_o == (high_vectors_o ? 32'hffff_0000 : 32'h0000_0000))
    else $error("Vector base disagrees with vector bit");

  a_ctrl_write: assert property (ce_i && wr && sel == scc_pkg::SCC_SEL_CTRL |=> mmu_enable_o == $past(xfer_wdata_i[0])
      && dcache_enable_o == $past(xfer_wdata_i[2]) && round_robin_replace_o == $past(xfer_wdata_i[14])
      && async_clock_select_o == $past(xfer_wdata_i[31]))
    else $error("Control write not stored");

  a_ctrl_read: assert property (ce_i && acc_ok && !xfer_write_i && sel == scc_pkg::SCC_SEL_CTRL
      |=> xfer_rvalid_o && xfer_rdata_o[6:3] == 4'hf && xfer_rdata_o[11:10] == 2'h0)
    else $error("Control read reserved fields wrong");

  a_table_write: assert property (ce_i && wr && sel == scc_pkg::SCC_SEL_TABLE
      |=> table_base_pointer_o == $past(xfer_wdata_i[31:14]))
    else $error("Table base not stored");

  a_dac_round: assert property (s_dac_write ##1 s_dac_read |=> xfer_rdata_o == $past(xfer_wdata_i, 2))
    else $error("Domain register read back wrong");

  a_fsr_capture: assert property (ce_i && data_abort_i |=> st_r.dfsr == {$past(abort_domain_i), $past(abort_type_i)})
    else $error("Data fault status not captured");

  a_far_data: assert property (ce_i && data_abort_i |=> st_r.fault_address == $past(modified_virtual_address_i))
    else $error("Fault address not captured");

  a_far_prefetch: assert property (ce_i && prefetch_abort_i && !data_abort_i && !(wr && sel == scc_pkg::SCC_SEL_FAR)
      |=> $stable(st_r.fault_address))
    else $error("Prefetch fault changed fault address");

  a_pfsr_sel: assert property (ce_i && acc_ok && !xfer_write_i && sel == scc_pkg::SCC_SEL_PFSR
      |=> xfer_rdata_o == {24'h000000, $past(st_r.pfsr)})
    else $error("Prefetch status read wrong");

  a_read_answer: assert property (ce_i && acc_ok && !xfer_write_i |=> xfer_rvalid_o && !undef_trap_o)
    else $error("Read not answered");

  a_no_stray_valid: assert property (ce_i && !(acc_ok && !xfer_write_i) |=> !xfer_rvalid_o)
    else $error("Read valid without a read");

  a_ctrl_rest: assert property (ce_i && wr && sel == scc_pkg::SCC_SEL_CTRL
      |=> icache_enable_o == $past(xfer_wdata_i[12])
      && big_endian_o == $past(xfer_wdata_i[7]) && align_check_o == $past(xfer_wdata_i[1])
      && high_vectors_o == $past(xfer_wdata_i[13]) && not_fast_bus_select_o == $past(xfer_wdata_i[30]))
    else $error("Control write bits not stored");

  a_prot_bits: assert property (ce_i && wr && sel == scc_pkg::SCC_SEL_CTRL
      |=> rom_protect_o == $past(xfer_wdata_i[9]) && system_protect_o == $past(xfer_wdata_i[8]))
    else $error("Protection bits not stored");

  a_dac_write: assert property (ce_i && wr && sel == scc_pkg::SCC_SEL_DAC |=> domain_access_o == $past(xfer_wdata_i))
    else $error("Domain register not stored");

  a_pfsr_capture: assert property (ce_i && prefetch_abort_i |=> st_r.pfsr == {$past(pf_domain_i), $past(pf_type_i)})
    else $error("Prefetch fault status not captured");

  a_dfsr_write: assert property (ce_i && wr && sel == scc_pkg::SCC_SEL_DFSR && !data_abort_i
      |=> st_r.dfsr == $past(xfer_wdata_i[7:0]))
    else $error("Fault status write not stored");

  a_far_write: assert property (ce_i && wr && sel == scc_pkg::SCC_SEL_FAR && !data_abort_i
      |=> st_r.fault_address == $past(xfer_wdata_i))
    else $error("Fault address write not stored");

  a_table_read: assert property (ce_i && acc_ok && !xfer_write_i && sel == scc_pkg::SCC_SEL_TABLE
      |=> xfer_rdata_o == {$past(st_r.table_base), 14'h0000})
    else $error("Table base read wrong");

  a_ce_freeze: assert property (!ce_i |=> $stable(st_r))
    else $error("State changed while clock enable low");

endmodule
